// File: include/ira_pkg.sv
/*
 * ira_pkg: constants, register map and carrier types of the indirect
 * register access unit.
 * Assumes a single 25 MHz device clock and an 8-bit register port.
 */
package ira_pkg;

   // timing
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned UPDATE_HZ = 16_000;
   localparam int unsigned UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;
   localparam int unsigned TICK_W = $clog2(UPDATE_CYCLES);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(UPDATE_CYCLES - 1);

   // register offsets
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h17;
   localparam logic [7:0] OFS_DATA_LOW = 8'h1C;
   localparam logic [7:0] OFS_DATA_HIGH = 8'h1D;
   localparam logic [7:0] OFS_ADDRESS = 8'h1E;
   localparam logic [7:0] OFS_ACCESS_STATUS = 8'h1F;

   // field positions
   localparam int unsigned SERVICED_BIT = 1;
   localparam int unsigned PENDING_BIT = 0;

   // reset values
   localparam logic [15:0] RST_DATA_WINDOW = 16'h0000;
   localparam logic [7:0] RST_TARGET_ADDRESS = 8'h00;
   localparam logic [7:0] RST_READ_DATA = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ira_bus_req_t;

   typedef enum logic [1:0] {
      IRA_IDLE,
      IRA_READ_PEND,
      IRA_WRITE_PEND
   } ira_phase_t;

   typedef struct packed {
      logic [TICK_W-1:0] tick_cnt;
      ira_phase_t phase;
      logic [15:0] data_window;
      logic [7:0] target_address;
      logic data_armed;
      logic serviced_irq_pending;
      logic serviced_irq_enable;
      logic [7:0] rdata;
   } ira_state_t;

endpackage : ira_pkg

// File: rtl/ira_indirect_access.sv
/*
 * ira_indirect_access: direct register window onto a bank of 16-bit
 * indirect registers, serviced at a periodic 16 kHz update instant.
 * Assumes register port strobes are synchronous to clk_i, one cycle
 * long and never both high together.
 */
// Overview of operation
// - data then address write stores data window
// - address-only write reads bank into window
// - status bit 0 shows access pending
// - enable bit 1 gates serviced interrupt
// - 16-bit data window, two byte registers
// - 8-bit read/write indirect address register
// - completion sets pending bit, write one clears
`timescale 1ns/10ps

module ira_indirect_access
#(
   parameter int unsigned IND_ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire ira_pkg::ira_bus_req_t bus_req_i,
   output logic [7:0] rdata_o,
   output logic irq_o
);
   import ira_pkg::*;

   localparam int unsigned IND_DEPTH = 2 ** IND_ADDR_W;

   ira_state_t state;
   ira_state_t next_state;
   logic [15:0] bank [IND_DEPTH];
   logic update_tick;
   logic bank_we;
   logic [15:0] bank_rdata;
   logic [IND_ADDR_W-1:0] bank_index;

   // one-bit field placed into a byte at a given position
   function automatic logic [7:0] place_bit(input logic value, input int unsigned pos);
      logic [7:0] result;
      result = 8'h00;
      result[pos[2:0]] = value;
      return result;
   endfunction : place_bit

   function automatic logic hit(input ira_bus_req_t req, input logic [7:0] ofs);
      return req.addr == ofs;
   endfunction : hit

   // pending flag as software sees it
   function automatic logic access_pending(input ira_phase_t phase);
      return phase != IRA_IDLE;
   endfunction : access_pending

   // kind of request that an address write starts
   function automatic ira_phase_t request_kind(input logic armed);
      ira_phase_t kind;
      kind = IRA_READ_PEND;
      if (armed)
      begin
         kind = IRA_WRITE_PEND;
      end
      return kind;
   endfunction : request_kind

   // update counter, wrapping at the last cycle of a period
   function automatic logic [TICK_W-1:0] tick_after(input logic [TICK_W-1:0] cnt);
      logic [TICK_W-1:0] result;
      result = TICK_W'(cnt + 1'b1);
      if (cnt == TICK_LAST)
      begin
         result = '0;
      end
      return result;
   endfunction : tick_after

   // one-hot decode of a register port write
   typedef struct packed {
      logic irq_status;
      logic irq_enable;
      logic data_low;
      logic data_high;
      logic address;
   } ira_wr_sel_t;

   function automatic ira_wr_sel_t decode_write(input ira_bus_req_t req);
      ira_wr_sel_t sel;
      sel.irq_status = req.wr && hit(req, OFS_IRQ_STATUS);
      sel.irq_enable = req.wr && hit(req, OFS_IRQ_ENABLE);
      sel.data_low = req.wr && hit(req, OFS_DATA_LOW);
      sel.data_high = req.wr && hit(req, OFS_DATA_HIGH);
      sel.address = req.wr && hit(req, OFS_ADDRESS);
      return sel;
   endfunction : decode_write

   // completion of a pending access at an update instant
   function automatic ira_state_t service(input ira_state_t s, input logic [15:0] fetched);
      ira_state_t result;
      result = s;
      unique case (s.phase)
         IRA_IDLE:
         begin
            result.phase = IRA_IDLE;
         end
         IRA_READ_PEND:
         begin
            result.data_window = fetched;
            result.phase = IRA_IDLE;
            result.serviced_irq_pending = 1'b1;
         end
         IRA_WRITE_PEND:
         begin
            result.phase = IRA_IDLE;
            result.serviced_irq_pending = 1'b1;
         end
      endcase
      return result;
   endfunction : service

   // register port writes, applied after the service of the same cycle
   function automatic ira_state_t apply_write(input ira_state_t s, input ira_wr_sel_t sel,
      input logic [7:0] wdata, input logic set_now);
      ira_state_t result;
      result = s;
      if (sel.irq_enable)
      begin
         result.serviced_irq_enable = wdata[SERVICED_BIT];
      end
      // a completion in the same cycle beats the clear
      if (sel.irq_status && wdata[SERVICED_BIT] && !set_now)
      begin
         result.serviced_irq_pending = 1'b0;
      end
      if (sel.data_low)
      begin
         result.data_window[7:0] = wdata;
         result.data_armed = 1'b1;
      end
      if (sel.data_high)
      begin
         result.data_window[15:8] = wdata;
         result.data_armed = 1'b1;
      end
      if (sel.address)
      begin
         result.target_address = wdata;
         result.data_armed = 1'b0;
         // a new address write replaces a request still pending
         result.phase = request_kind(s.data_armed);
      end
      return result;
   endfunction : apply_write

   // byte on the read port for one offset, zero where nothing is mapped
   function automatic logic [7:0] read_byte(input ira_state_t s, input logic [7:0] ofs);
      logic [7:0] result;
      result = 8'h00;
      unique case (ofs)
         OFS_IRQ_STATUS:
         begin
            result = place_bit(s.serviced_irq_pending, SERVICED_BIT);
         end
         OFS_IRQ_ENABLE:
         begin
            result = place_bit(s.serviced_irq_enable, SERVICED_BIT);
         end
         OFS_DATA_LOW:
         begin
            result = s.data_window[7:0];
         end
         OFS_DATA_HIGH:
         begin
            result = s.data_window[15:8];
         end
         OFS_ADDRESS:
         begin
            result = s.target_address;
         end
         OFS_ACCESS_STATUS:
         begin
            result = place_bit(access_pending(s.phase), PENDING_BIT);
         end
         default:
         begin
            result = 8'h00;
         end
      endcase
      return result;
   endfunction : read_byte

   ira_wr_sel_t wr_sel;
   logic serviced_now;

   assign update_tick = (state.tick_cnt == TICK_LAST);
   assign bank_index = state.target_address[IND_ADDR_W-1:0];
   assign bank_rdata = bank[bank_index];
   assign bank_we = update_tick && (state.phase == IRA_WRITE_PEND);
   assign wr_sel = decode_write(bus_req_i);
   assign serviced_now = update_tick && access_pending(state.phase);

   always_comb
   begin
      next_state = state;
      next_state.tick_cnt = tick_after(state.tick_cnt);

      // periodic service first, so that a write in the same cycle wins, except a status clear, which a completion beats
      if (update_tick)
      begin
         next_state = service(next_state, bank_rdata);
      end

      // register writes
      next_state = apply_write(next_state, wr_sel, bus_req_i.wdata, serviced_now);

      // register reads, data one cycle after the strobe
      next_state.rdata = RST_READ_DATA;
      if (bus_req_i.rd)
      begin
         next_state.rdata = read_byte(state, bus_req_i.addr);
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state.tick_cnt <= '0;
         state.phase <= IRA_IDLE;
         state.data_window <= RST_DATA_WINDOW;
         state.target_address <= RST_TARGET_ADDRESS;
         state.data_armed <= 1'b0;
         state.serviced_irq_pending <= 1'b0;
         state.serviced_irq_enable <= 1'b0;
         state.rdata <= RST_READ_DATA;
      end
      else
      begin
         state <= next_state;
      end
   end

   // indirect bank, no reset
   always_ff @(posedge clk_i)
   begin
      if (bank_we)
      begin
         bank[bank_index] <= state.data_window;
      end
   end

   assign rdata_o = state.rdata;
   assign irq_o = state.serviced_irq_pending & state.serviced_irq_enable;

endmodule : ira_indirect_access

// File: bench/ira_props.sv
/* ira_props: port assertions for ira_indirect_access.
   Assumes one clk_i domain and the package tick period. */
`timescale 1ns/10ps
module ira_props
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire ira_pkg::ira_bus_req_t bus_req_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o
);
   import ira_pkg::*;
   logic [TICK_W-1:0] cnt;
   wire logic w = bus_req_i.wr;
   wire logic r = bus_req_i.rd;
   wire logic [7:0] a = bus_req_i.addr;
   wire logic [7:0] d = bus_req_i.wdata;
   wire logic tick = cnt == TICK_LAST;
   wire logic en_wr = w && a == OFS_IRQ_ENABLE;
   // mirrors the update tick
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt <= '0;
      end
      else
      begin
         cnt <= tick ? '0 : TICK_W'(cnt + 1'b1);
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   property p_idle; rdata_o != 8'h00 |-> $past(r); endproperty
   property p_stat; r && a == OFS_ACCESS_STATUS |=> rdata_o[7:1] == 7'h00; endproperty
   property p_en; r && a == OFS_IRQ_ENABLE |=> (rdata_o & 8'hFD) == 8'h00; endproperty
   property p_mask; en_wr && !d[1] |=> !irq_o; endproperty
   property p_clr; w && a == OFS_IRQ_STATUS && d[1] && !tick |=> !irq_o; endproperty
   property p_rise; $rose(irq_o) |-> $past(tick) || $past(en_wr); endproperty
   property p_addr; w && a == OFS_ADDRESS ##2 r && a == OFS_ADDRESS |=> rdata_o == $past(d, 3);
   endproperty
   property p_pend; w && a == OFS_ADDRESS && cnt < TICK_LAST - 6 ##4
      r && a == OFS_ACCESS_STATUS |=> rdata_o[0]; endproperty
   a_idle: assert property (p_idle) else $error("read data outside read");
   a_stat: assert property (p_stat) else $error("status reserved bits set");
   a_en: assert property (p_en) else $error("enable reserved bits set");
   a_mask: assert property (p_mask) else $error("masked interrupt high");
   a_clr: assert property (p_clr) else $error("interrupt not cleared");
   a_rise: assert property (p_rise) else $error("interrupt off tick");
   a_addr: assert property (p_addr) else $error("address readback wrong");
   a_pend: assert property (p_pend) else $error("pending flag low");
   c_irq: cover property ($rose(irq_o));
   c_pend: cover property (r && a == OFS_ACCESS_STATUS ##1 rdata_o[0]);
   c_clr: cover property (w && a == OFS_IRQ_STATUS && d[1]);
endmodule : ira_props

bind ira_indirect_access ira_props u_props (.clk_i(clk_i), .nrst_i(nrst_i),
   .bus_req_i(bus_req_i), .rdata_o(rdata_o), .irq_o(irq_o));

// File: bench/ira_indirect_access_tb.sv
/* ira_indirect_access_tb: self-checking bench with a bank model.
   Assumes the package tick period and a 25 MHz clock. */
`timescale 1ns/10ps
module ira_indirect_access_tb;
   import ira_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   ira_bus_req_t req = '0;
   logic [7:0] rdata;
   logic irq;
   logic en = 1'b0;
   int bad_count = 0;
   int n_checks = 0;
   logic [15:0] bank [int];
   logic [15:0] win;
   ira_indirect_access DUT (.clk_i(clk_i), .nrst_i(nrst_i), .bus_req_i(req),
      .rdata_o(rdata), .irq_o(irq));
   initial forever #20 clk_i = ~clk_i;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk_i);
      req.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_i);
      req.rd <= 1'b0;
      @(negedge clk_i);
      chk(rdata, exp);
   endtask : rd
   // one indirect access, completion awaited over one full tick period
   task access(input logic [7:0] a, input bit wop, input logic [15:0] d);
      if (wop)
      begin
         wr(OFS_DATA_LOW, d[7:0]);
         wr(OFS_DATA_HIGH, d[15:8]);
         bank[a] = d;
      end
      win = bank[a];
      wr(OFS_ADDRESS, a);
      rd(OFS_ADDRESS, a);
      rd(OFS_ACCESS_STATUS, 8'h01);
      repeat (UPDATE_CYCLES) @(posedge clk_i);
      rd(OFS_ACCESS_STATUS, 8'h00);
      chk({7'h00, irq}, {7'h00, en});
      rd(OFS_IRQ_STATUS, 8'h02);
      wr(OFS_IRQ_STATUS, 8'h02);
      rd(OFS_IRQ_STATUS, 8'h00);
      rd(OFS_DATA_LOW, win[7:0]);
      rd(OFS_DATA_HIGH, win[15:8]);
   endtask : access
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      #800_000;
      bad_count++;
      give_verdict;
   end
   initial
   begin
      logic [7:0] a1;
      logic [15:0] d1;
      a1 = 8'($urandom(41));
      d1 = 16'($urandom);
      repeat (16) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(OFS_IRQ_ENABLE, 8'h00);
      rd(OFS_DATA_LOW, 8'h00);
      rd(OFS_DATA_HIGH, 8'h00);
      wr(OFS_ACCESS_STATUS, 8'hFF);
      rd(OFS_ACCESS_STATUS, 8'h00);
      rd(8'h00, 8'h00);
      wr(OFS_IRQ_ENABLE, 8'hFF);
      rd(OFS_IRQ_ENABLE, 8'h02);
      en = 1'b1;
      access(a1, 1'b1, d1);
      access(a1 ^ 8'h01, 1'b1, ~d1);
      wr(OFS_IRQ_ENABLE, 8'h00);
      en = 1'b0;
      access(a1, 1'b0, 16'h0000);
      // second reset in mid-run clears the loaded window
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd(OFS_DATA_LOW, 8'h00);
      rd(OFS_DATA_HIGH, 8'h00);
      rd(OFS_ACCESS_STATUS, 8'h00);
      chk({7'h00, irq}, 8'h00);
      give_verdict;
   end
endmodule : ira_indirect_access_tb
